// [logic/ssq_params.svh]
// constants for the serial frame sequencer
`ifndef SSQ_PARAMS_SVH
`define SSQ_PARAMS_SVH
`define SSQ_RES_W 14
`define SSQ_RAW_W 16
`define SSQ_CNT_W 5
`define SSQ_CNT_ZERO 5'h00
`define SSQ_CNT_ONE 5'h01
`define SSQ_CNT_MAX 5'h1F
`define SSQ_LEAD_LAST 5'h02
`define SSQ_MSB_EDGE 5'h03
`define SSQ_ACQ_EDGE 5'h10
`define SSQ_FIFO_DEPTH 8
`define SSQ_FS_POS 14'h1FFF
`define SSQ_FS_NEG 14'h2000
`define SSQ_RAW_POS 16'h1FFF
`define SSQ_RAW_NEG 16'hE000
`endif

// [logic/ssq_pkg.sv]
// types shared by the serial frame sequencer
package ssq_pkg;
   typedef enum logic [1:0] {
      SSQ_IDLE,
      SSQ_ARMED,
      SSQ_CONVERT,
      SSQ_TRACK
   } ssq_state_t;

   // one result word as it sits in the buffer
   typedef struct packed {
      logic [13:0] code;
   } ssq_word_t;

   // serial data pin split into level and enable
   typedef struct packed {
      logic data;
      logic oe;
   } ssq_dout_t;
endpackage

// [logic/ssq_fifo.sv]
// result buffer: its module sits beside its only user in ssq_sequencer.sv

// [logic/ssq_sequencer.sv]
// frame sequencer for the read-only serial port of a sar converter
`timescale 1ns/1ps
`include "ssq_params.svh"

// How it works
// - a frame runs from select falling to select rising; each fall restarts
// - data pin driven only while select is low, released while high
// - the input is sampled at the moment select goes low
// - first fifteen clock periods after select falls are conversion
// - sixteenth serial clock fall enters low-power acquisition, tracking input
// - select falling with clock high: counting starts at next clock fall
// - select falling with clock low counts as the first clock fall
// - select and clock falling together still enter conversion once
// - select high always means acquisition at minimum power
// - exactly one conversion per select assertion
// - data changes on falls: two zeros, then fourteen bits msb first
// - result bits are two's complement
// - no clock needed after sixteenth rising edge; clock may idle
// - select rising before sixteenth fall aborts and releases the pin
// - each bit appears when resolved, so frames may end early
// - full scale codes are 1FFF positive and 2000 negative
module ssq_sequencer #(
   parameter int FIFO_DEPTH = `SSQ_FIFO_DEPTH
) (
   input wire logic clk_sys, // system clock, 40 MHz
   input wire logic rst_b, // sync reset, active low
   input wire logic frame_select_n, // frame select, active low
   input wire logic serial_clk, // serial clock level
   output logic sdo_out, // serial data level
   output logic sdo_oe, // serial data enable, high drives
   input wire logic res_valid, // core offers a raw result
   output logic res_ready, // buffer accepts the result
   input wire logic [15:0] res_raw, // raw signed result from core
   output logic sample_pulse, // one cycle: hold the input now
   output logic converting, // conversion window active
   output logic low_power, // acquisition window or idle
   output logic underrun // one cycle: no result when msb due
);
   generate
      if (FIFO_DEPTH < 2)
      begin : g_bad_depth
         $error("ssq_sequencer needs a buffer of at least two words");
      end
   endgenerate

   logic cs_prev_ff;
   logic sclk_prev_ff;
   logic [`SSQ_CNT_W-1:0] cnt_ff;
   logic [`SSQ_CNT_W-1:0] nxt_cnt;
   logic [`SSQ_RES_W-1:0] shift_ff;
   logic [`SSQ_RES_W-1:0] nxt_shift;
   logic sdo_ff;
   logic nxt_sdo;
   logic sample_ff;
   logic underrun_ff;
   ssq_pkg::ssq_state_t state_ff;
   ssq_pkg::ssq_state_t nxt_state;
   ssq_pkg::ssq_word_t push_word;
   ssq_pkg::ssq_word_t head_word;
   ssq_pkg::ssq_dout_t dout;

   wire in_frame;
   wire cs_fall;
   wire sclk_fall;
   wire edge_ev;
   wire [`SSQ_CNT_W-1:0] edge_num;
   wire lead_edge;
   wire msb_edge;
   wire body_edge;
   wire head_valid;
   wire head_take;
   wire raw_hi;
   wire raw_lo;

   // clamp the core's wider result onto the 14-bit code range
   assign raw_hi = $signed(res_raw) > $signed(`SSQ_RAW_POS);
   assign raw_lo = $signed(res_raw) < $signed(`SSQ_RAW_NEG);
   assign push_word.code = raw_hi ? `SSQ_FS_POS :
                           raw_lo ? `SSQ_FS_NEG :
                           res_raw[`SSQ_RES_W-1:0];

   ssq_fifo #(
      .W(`SSQ_RES_W),
      .D(FIFO_DEPTH)
   ) u_fifo (
      .clk_sys(clk_sys),
      .rst_b(rst_b),
      .in_valid(res_valid),
      .in_ready(res_ready),
      .in_data(push_word),
      .out_valid(head_valid),
      .out_ready(head_take),
      .out_data(head_word)
   );

   // frame edges and serial clock falls seen on the system clock
   assign in_frame = !frame_select_n;
   assign cs_fall = cs_prev_ff && !frame_select_n;
   assign sclk_fall = sclk_prev_ff && !serial_clk;
   // select falling onto a low clock counts as a fall, once only
   assign edge_ev = in_frame
                    && (sclk_fall || (cs_fall && !serial_clk));
   assign edge_num = cnt_ff + `SSQ_CNT_ONE;

   // which bit slot the current fall belongs to
   assign lead_edge = edge_ev && (edge_num <= `SSQ_LEAD_LAST);
   assign msb_edge = edge_ev && (edge_num == `SSQ_MSB_EDGE);
   assign body_edge = edge_ev && (edge_num > `SSQ_MSB_EDGE)
                      && (edge_num <= `SSQ_ACQ_EDGE);
   // one result consumed per frame, at the msb slot
   assign head_take = msb_edge;

   // falling edge counter, cleared whenever select is high
   always_comb
   begin
      nxt_cnt = cnt_ff;
      if (!in_frame)
      begin
         nxt_cnt = `SSQ_CNT_ZERO;
      end
      else if (edge_ev && cnt_ff != `SSQ_CNT_MAX)
      begin
         nxt_cnt = edge_num;
      end
   end

   // mode follows the count: armed, converting, then tracking
   always_comb
   begin
      nxt_state = ssq_pkg::SSQ_IDLE;
      if (in_frame)
      begin
         if (nxt_cnt == `SSQ_CNT_ZERO)
         begin
            nxt_state = ssq_pkg::SSQ_ARMED;
         end
         else if (nxt_cnt < `SSQ_ACQ_EDGE)
         begin
            nxt_state = ssq_pkg::SSQ_CONVERT;
         end
         else
         begin
            nxt_state = ssq_pkg::SSQ_TRACK;
         end
      end
   end

   // data bit per fall; bits leave as soon as they are due
   always_comb
   begin
      nxt_sdo = sdo_ff;
      nxt_shift = shift_ff;
      if (!in_frame)
      begin
         nxt_sdo = 1'b0;
      end
      else if (lead_edge)
      begin
         nxt_sdo = 1'b0;
      end
      else if (msb_edge)
      begin
         // an empty buffer sends zeros rather than stale data
         nxt_sdo = head_valid && head_word.code[`SSQ_RES_W-1];
         nxt_shift = head_valid ? {head_word.code[`SSQ_RES_W-2:0], 1'b0}
                                : '0;
      end
      else if (body_edge)
      begin
         nxt_sdo = shift_ff[`SSQ_RES_W-1];
         nxt_shift = {shift_ff[`SSQ_RES_W-2:0], 1'b0};
      end
      else if (edge_ev)
      begin
         nxt_sdo = 1'b0; // past the lsb the line rests low
      end
   end

   // edge history; select reset to idle high, so a select held low through reset reads as a fall
   always_ff @(posedge clk_sys)
   begin
      if (!rst_b)
      begin
         cs_prev_ff <= 1'b1;
         sclk_prev_ff <= 1'b0;
      end
      else
      begin
         cs_prev_ff <= frame_select_n;
         sclk_prev_ff <= serial_clk;
      end
   end

   // sequencing state
   always_ff @(posedge clk_sys)
   begin
      if (!rst_b)
      begin
         cnt_ff <= `SSQ_CNT_ZERO;
         state_ff <= ssq_pkg::SSQ_IDLE;
         shift_ff <= '0;
         sdo_ff <= 1'b0;
      end
      else
      begin
         cnt_ff <= nxt_cnt;
         state_ff <= nxt_state;
         shift_ff <= nxt_shift;
         sdo_ff <= nxt_sdo;
      end
   end

   // event pulses, one cycle each
   always_ff @(posedge clk_sys)
   begin
      if (!rst_b)
      begin
         sample_ff <= 1'b0;
         underrun_ff <= 1'b0;
      end
      else
      begin
         sample_ff <= cs_fall;
         underrun_ff <= msb_edge && !head_valid;
      end
   end

   // enable follows select directly so release is immediate
   assign dout.oe = in_frame;
   assign dout.data = sdo_ff;
   assign sdo_out = dout.data;
   assign sdo_oe = dout.oe;
   assign sample_pulse = sample_ff;
   assign underrun = underrun_ff;
   assign converting = (state_ff == ssq_pkg::SSQ_CONVERT);
   assign low_power = (state_ff == ssq_pkg::SSQ_IDLE)
                      || (state_ff == ssq_pkg::SSQ_TRACK);
endmodule

module ssq_fifo #(
   parameter int W = 14,
   parameter int D = 8
) (
   input wire logic clk_sys, // system clock
   input wire logic rst_b, // sync reset, active low
   input wire logic in_valid, // writer offers a word
   output logic in_ready, // buffer has room
   input wire logic [W-1:0] in_data, // word offered
   output logic out_valid, // buffer holds a word
   input wire logic out_ready, // reader takes the head
   output logic [W-1:0] out_data // head word
);
   localparam int AW = $clog2(D);

   // pointer arithmetic relies on a power of two depth
   generate
      if (D < 2 || (D & (D - 1)) != 0)
      begin : g_bad_depth
         $error("ssq_fifo depth must be a power of two, at least 2");
      end
   endgenerate

   logic [W-1:0] mem [D];
   logic [AW:0] wp_ff;
   logic [AW:0] rp_ff;
   wire full;
   wire empty;
   wire push;
   wire pop;

   // extra pointer bit tells full from empty
   assign full = (wp_ff[AW] != rp_ff[AW]) && (wp_ff[AW-1:0] == rp_ff[AW-1:0]);
   assign empty = (wp_ff == rp_ff);
   assign push = in_valid && !full;
   assign pop = out_ready && !empty;
   assign in_ready = !full;
   assign out_valid = !empty;
   assign out_data = mem[rp_ff[AW-1:0]];

   // storage needs no reset, pointers do
   always_ff @(posedge clk_sys)
   begin
      if (push)
      begin
         mem[wp_ff[AW-1:0]] <= in_data;
      end
   end

   always_ff @(posedge clk_sys)
   begin
      if (!rst_b)
      begin
         wp_ff <= '0;
         rp_ff <= '0;
      end
      else
      begin
         wp_ff <= wp_ff + (AW + 1)'(push);
         rp_ff <= rp_ff + (AW + 1)'(pop);
      end
   end
endmodule

// [testbench/ssq_sequencer_asserts.sv]
// port-level checks for the serial frame sequencer
`timescale 1ns/1ps
module ssq_sequencer_chk (
   input wire logic clk_sys, // clock
   input wire logic rst_b, // reset
   input wire logic frame_select_n, // select
   input wire logic serial_clk, // serial clock
   input wire logic sdo_out, // data
   input wire logic sdo_oe, // data enable
   input wire logic sample_pulse, // sample strobe
   input wire logic converting, // converting
   input wire logic low_power // low power
);
   logic ps_ff;
   logic pc_ff;
   logic [4:0] cnt_ff;
   logic ev;
   logic in_conv;
   // own fall-event count, kept apart from the design's
   assign ev = !frame_select_n && !serial_clk && (ps_ff || pc_ff);
   assign in_conv = cnt_ff != 5'h00 && cnt_ff < 5'h10;
   always_ff @(posedge clk_sys)
   begin
      ps_ff <= rst_b ? frame_select_n : 1'b1;
      pc_ff <= rst_b ? serial_clk : 1'b0;
      cnt_ff <= (!rst_b || frame_select_n) ? 5'h00 : cnt_ff + {4'h0, ev};
   end
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rst_b);
   sequence s_sel_fall;
      $fell(frame_select_n);
   endsequence
   sequence s_quiet;
      !sdo_out && !converting;
   endsequence
   a_oe_follows_sel:
      assert property (sdo_oe == !frame_select_n) else $error("enable");
   a_sample_on_fall:
      assert property (s_sel_fall |=> sample_pulse) else $error("sample");
   a_one_sample:
      assert property (sample_pulse |-> $past(frame_select_n, 2)
         && !$past(frame_select_n)) else $error("stray sample");
   a_idle_low_power:
      assert property (frame_select_n |=> low_power && !converting)
         else $error("idle power");
   a_conv_window:
      assert property (converting == in_conv) else $error("conv window");
   a_track_at_16:
      assert property (cnt_ff == 5'h10 |-> low_power && !converting)
         else $error("track");
   a_lead_zeros:
      assert property (cnt_ff inside {5'h01, 5'h02} |-> !sdo_out)
         else $error("lead zero");
   a_data_on_fall:
      assert property ($changed(sdo_out) |-> $past(ev)
         || $past(frame_select_n)) else $error("data moved");
   a_abort_quiet:
      assert property ($rose(frame_select_n) |=> s_quiet)
         else $error("abort");
endmodule

bind ssq_sequencer ssq_sequencer_chk u_chk (
   .clk_sys(clk_sys),
   .rst_b(rst_b),
   .frame_select_n(frame_select_n),
   .serial_clk(serial_clk),
   .sdo_out(sdo_out),
   .sdo_oe(sdo_oe),
   .sample_pulse(sample_pulse),
   .converting(converting),
   .low_power(low_power)
);

// [testbench/ssq_host_model.sv]
// controller model: drives select and serial clock, captures data
`timescale 1ns/1ps
module ssq_host_model (
   input wire logic clk_sys, // system clock
   input wire logic sdo_out, // data level
   input wire logic sdo_oe, // data enable
   output logic frame_select_n, // select, active low
   output logic serial_clk, // serial clock
   output logic done, // one cycle: word captured
   output logic [15:0] got // captured bits, last in lsb
);
   initial
   begin
      frame_select_n = 1'b1;
      serial_clk = 1'b0;
      done = 1'b0;
      got = 16'h0000;
   end
   task automatic wt(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask
   // m: 0 clock low, 1 clock high, 2 both falling together
   task automatic frame(input int nf, input int m);
      int i;
      got = 16'h0000; // short frames must not inherit old bits
      wt(4); // acquisition gap
      serial_clk = (m != 0);
      wt(2);
      frame_select_n = 1'b0; // never on a rising clock
      serial_clk = (m == 1);
      if (m == 1)
      begin
         wt(2);
         serial_clk = 1'b0;
      end
      for (i = 0; i < nf; i++)
      begin
         wt(2);
         serial_clk = 1'b1;
         // undriven line shows a changing level
         got = {got[14:0], sdo_oe ? sdo_out : ~got[0]};
         wt(2);
         serial_clk = 1'b0;
      end
      // two more periods make an eighteen-clock frame
      if (m == 0 && nf == 16)
      begin
         repeat (2)
         begin
            wt(2);
            serial_clk = 1'b1;
            wt(2);
            serial_clk = 1'b0;
         end
      end
      wt(1);
      frame_select_n = 1'b1; // clock then idles
      done = 1'b1;
      wt(1);
      done = 1'b0;
   endtask
endmodule

// [testbench/ssq_sequencer_tb.sv]
// self-checking bench for the serial frame sequencer
`timescale 1ns/1ps
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin errors++; \
$display("CHECK FAILED %s exp %h got %h", n, e, g); end end
module ssq_sequencer_tb;
   logic clk_sys = 1'b0;
   logic rst_b = 1'b0;
   logic res_valid = 1'b0;
   logic [15:0] res_raw = 16'h0000;
   logic [15:0] got;
   logic [15:0] e_w;
   logic [31:0] r;
   logic [15:0] exp_q[$];
   logic [13:0] code_q[$];
   wire fs_n, sclk, sdo_out, sdo_oe, res_ready, done;
   wire sample_pulse, converting, low_power, underrun;
   int errors = 0;
   int checked = 0;
   int n_und = 0;
   int n_smp = 0;
   int k;
   int seed = 32'h193c_da7f;
   always #12.5 clk_sys = ~clk_sys;
   ssq_sequencer #(.FIFO_DEPTH(8)) DUT (.clk_sys(clk_sys), .rst_b(rst_b),
      .frame_select_n(fs_n), .serial_clk(sclk), .sdo_out(sdo_out),
      .sdo_oe(sdo_oe), .res_valid(res_valid), .res_ready(res_ready),
      .res_raw(res_raw), .sample_pulse(sample_pulse),
      .converting(converting), .low_power(low_power), .underrun(underrun));
   ssq_host_model host (.clk_sys(clk_sys), .sdo_out(sdo_out),
      .sdo_oe(sdo_oe), .frame_select_n(fs_n), .serial_clk(sclk),
      .done(done), .got(got));
   task report_and_stop;
      if (errors == 0 && checked > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   // full-scale clamp of the raw word
   function logic [13:0] clamp(input logic [15:0] v);
      if ($signed(v) > $signed(16'h1FFF))
         return 14'h1FFF;
      if ($signed(v) < $signed(16'hE000))
         return 14'h2000;
      return v[13:0];
   endfunction
   // valid stays up between pushes; caller lowers it
   task push(input logic [15:0] v);
      int i;
      i = 0;
      res_valid = 1'b1;
      res_raw = v;
      while (!res_ready && i < 50)
      begin
         @(posedge clk_sys) #1;
         i++;
      end
      if (i == 50)
      begin
         errors++;
         report_and_stop;
      end
      @(posedge clk_sys) #1;
      code_q.push_back(clamp(v));
   endtask
   // note the expected bits, then run one frame
   task run(input int nf, input int m);
      logic [15:0] w;
      w = {2'b00, code_q.size() ? code_q.pop_front() : 14'h0000};
      exp_q.push_back(w >> (16 - nf));
      host.frame(nf, m);
   endtask
   // scoreboard: each captured word meets the oldest note
   always @(posedge clk_sys)
   begin
      if (done)
      begin
         e_w = exp_q.pop_front();
         `CHK("frame bits", e_w, got)
      end
      if (underrun)
         n_und++;
      if (sample_pulse)
         n_smp++;
   end
   initial
   begin
      repeat (100000) @(posedge clk_sys);
      errors++;
      report_and_stop;
   end
   initial
   begin
      repeat (10) @(posedge clk_sys);
      #1 rst_b = 1'b1;
      push(16'h7FFF);
      push(16'h8000);
      for (k = 0; k < 6; k++)
      begin
         r = $random(seed);
         push(r[15:0]);
      end
      res_raw = 16'h0123; // refused while full
      repeat (3) @(posedge clk_sys);
      #1;
      `CHK("ready when full", 1'b0, res_ready)
      res_valid = 1'b0;
      // short frame and all three entry modes
      for (k = 0; k < 8; k++)
         run(k == 2 ? 10 : 16, k % 3);
      run(16, 0); // empty buffer gives zeros
      repeat (4) @(posedge clk_sys);
      `CHK("underruns", 1, n_und)
      `CHK("samples", 9, n_smp)
      report_and_stop;
   end
endmodule
